/* pkg/phy_regs_pkg.sv */
// Constants and carrier types for the PHY status and auto-negotiation registers
package phy_regs_pkg;

  // Register indexes as selected by the MAC side
  localparam logic [4:0] IDX_STATUS  = 5'h01;
  localparam logic [4:0] IDX_IDENT_H = 5'h02;
  localparam logic [4:0] IDX_IDENT_L = 5'h03;
  localparam logic [4:0] IDX_ADV     = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;

  // Basic status field positions
  localparam int ST_ABIL_HI = 15;
  localparam int ST_ABIL_LO = 11;
  localparam int ST_AN_DONE = 5;
  localparam int ST_RFAULT  = 4;
  localparam int ST_AN_ABLE = 3;
  localparam int ST_LINK    = 2;
  localparam int ST_JABBER  = 1;
  localparam int ST_EXTCAP  = 0;

  // No T4, then 100 full, 100 half, 10 full, 10 half
  localparam logic [4:0] ST_ABILITY = 5'h0f;

  // Advertisement and partner field positions
  localparam int AN_NEXT_PAGE = 15;
  localparam int AN_ACK       = 14;
  localparam int AN_RFAULT    = 13;
  localparam int AN_PAUSE_SYM = 10;
  localparam int AN_PAUSE_ASY = 11;

  // Reset values
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [15:0] LP_RESET  = 16'h0001;
  // Writable advertisement bits: 13, 11:10, 8:5 and the selector
  localparam logic [15:0] ADV_WMASK = 16'h2dff;
  // Partner bits taken from a received base page (15 and 12 stay 0)
  localparam logic [15:0] LP_TAKE   = 16'h2fff;

  // One management access from the MAC side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  index;
    logic [15:0] wdata;
  } mgmt_req_type;

  // Live conditions from the auto-negotiation engine and receive logic
  typedef struct packed {
    logic        an_complete;
    logic        remote_fault;
    logic        link_up;
    logic        jabber;
    logic        page_rx;
    logic [15:0] page_word;
  } phy_event_type;

endpackage : phy_regs_pkg

/* rtl/phy_status_autoneg_regs.sv */
// PHY basic status, identifier and auto-negotiation registers at indexes 1 to 5
`timescale 1ns/1ps

module phy_status_autoneg_regs
  import phy_regs_pkg::*;
#(
  parameter logic [15:0] IDENT_HIGH_RST = 16'h5a5a, // Arbitrary value
  parameter logic [5:0]  IDENT_OUI_RST  = 6'h15,    // Arbitrary value
  parameter logic [5:0]  MODEL_RST      = 6'h0a,    // Arbitrary value
  parameter logic [3:0]  REVISION_RST   = 4'h1      // Arbitrary value
)
(
  input  wire logic                       SYS_CLK,
  input  wire logic                       SYS_RST,
  input  wire phy_regs_pkg::mgmt_req_type  MGMT_REQ,
  input  wire phy_regs_pkg::phy_event_type PHY_EVT,
  output logic [15:0]                     REG_RDATA,
  output logic                            REG_RVALID,
  output logic [15:0]                     ADV_WORD,
  output logic                            PAUSE_SYM_EN,
  output logic                            PAUSE_ASYM_EN
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] rdata;
    logic        rvalid;
    logic        rf_latch;
    logic        link_latch;
    logic        jab_latch;
    logic [15:0] ident_high;
    logic [15:0] ident_low;
    logic [15:0] adv;
    logic [15:0] lp;
    logic        pause_sym;
    logic        pause_asym;
  } state_type;

  localparam logic [15:0] IDENT_LOW_RST =
    {IDENT_OUI_RST, MODEL_RST, REVISION_RST};

  state_type st_r;
  state_type st_nxt;
  logic [15:0] status_word;
  logic        rd_status;

  // Status word as seen by a read this cycle
  always_comb
  begin
    status_word = 16'h0000;
    status_word[ST_ABIL_HI:ST_ABIL_LO] = ST_ABILITY;
    status_word[ST_AN_DONE] = PHY_EVT.an_complete;
    status_word[ST_RFAULT]  = st_r.rf_latch;
    status_word[ST_AN_ABLE] = 1'b1;
    status_word[ST_LINK]    = st_r.link_latch;
    status_word[ST_JABBER]  = st_r.jab_latch;
    status_word[ST_EXTCAP]  = 1'b1;
  end

  assign rd_status = MGMT_REQ.rd && (MGMT_REQ.index == IDX_STATUS);

  // Next-state logic for the whole register set
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = MGMT_REQ.rd;

    // Indexed read; unmapped indexes and reserved bits return zero
    unique case (MGMT_REQ.index)
      IDX_STATUS:  st_nxt.rdata = status_word;
      IDX_IDENT_H: st_nxt.rdata = st_r.ident_high;
      IDX_IDENT_L: st_nxt.rdata = st_r.ident_low;
      IDX_ADV:     st_nxt.rdata = st_r.adv;
      IDX_PARTNER: st_nxt.rdata = st_r.lp;
      default:     st_nxt.rdata = 16'h0000;
    endcase
    if (!MGMT_REQ.rd)
    begin
      st_nxt.rdata = st_r.rdata;
    end

    // Latches: a read lets each flag fall back to the live condition.
    // An event in the read cycle is the live value, so it is never lost.
    if (rd_status)
    begin
      st_nxt.rf_latch   = PHY_EVT.remote_fault;
      st_nxt.jab_latch  = PHY_EVT.jabber;
      st_nxt.link_latch = PHY_EVT.link_up;
    end
    else
    begin
      st_nxt.rf_latch   = st_r.rf_latch | PHY_EVT.remote_fault;
      st_nxt.jab_latch  = st_r.jab_latch | PHY_EVT.jabber;
      st_nxt.link_latch = st_r.link_latch & PHY_EVT.link_up;
    end

    // Writes; status and partner registers are read-only
    if (MGMT_REQ.wr)
    begin
      unique case (MGMT_REQ.index)
        IDX_IDENT_H: st_nxt.ident_high = MGMT_REQ.wdata;
        IDX_IDENT_L: st_nxt.ident_low  = MGMT_REQ.wdata;
        IDX_ADV:
        begin
          // Only the writable fields take the new value
          st_nxt.adv = (MGMT_REQ.wdata & ADV_WMASK)
                     | (st_r.adv & ~ADV_WMASK);
        end
        default: st_nxt.adv = st_r.adv;
      endcase
    end

    // Base page from the partner loads the ability fields
    if (PHY_EVT.page_rx)
    begin
      st_nxt.lp = PHY_EVT.page_word & LP_TAKE;
      st_nxt.lp[AN_ACK] = 1'b1;
      st_nxt.lp[AN_NEXT_PAGE] = 1'b0;
    end

    // Pause resolution; symmetric takes precedence so both never hold
    if (PHY_EVT.an_complete)
    begin
      st_nxt.pause_sym  = st_r.adv[AN_PAUSE_SYM]
                        & st_r.lp[AN_PAUSE_SYM];
      st_nxt.pause_asym = !st_nxt.pause_sym
                        & st_r.adv[AN_PAUSE_ASY]
                        & st_r.lp[AN_PAUSE_ASY];
    end
    else
    begin
      st_nxt.pause_sym  = 1'b0;
      st_nxt.pause_asym = 1'b0;
    end
  end

  // State register with hardware reset to the documented defaults
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_r            <= '0;
      st_r.ident_high <= IDENT_HIGH_RST;
      st_r.ident_low  <= IDENT_LOW_RST;
      st_r.adv        <= ADV_RESET;
      st_r.lp         <= LP_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops
  assign REG_RDATA     = st_r.rdata;
  assign REG_RVALID    = st_r.rvalid;
  assign ADV_WORD      = st_r.adv;
  assign PAUSE_SYM_EN  = st_r.pause_sym;
  assign PAUSE_ASYM_EN = st_r.pause_asym;

  // Checks on the register behaviour
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  chk_fixed_ability: assert property (
    $past(rd_status) |-> REG_RVALID
      && REG_RDATA[15:11] == 5'h0f
      && REG_RDATA[3] && REG_RDATA[0]
      && REG_RDATA[10:6] == 5'h00)
    else $error("Status ability bits wrong");

  chk_an_done_bit: assert property (
    rd_status |=> REG_RDATA[5] == $past(PHY_EVT.an_complete))
    else $error("Auto-negotiation done bit wrong");

  chk_fault_latch: assert property (
    PHY_EVT.remote_fault && !rd_status ##1 !rd_status [*2]
      |-> st_r.rf_latch)
    else $error("Remote fault did not latch");

  chk_link_low: assert property (
    !PHY_EVT.link_up ##1 (!rd_status && PHY_EVT.link_up) [*2]
      |-> !st_r.link_latch)
    else $error("Link loss did not latch");

  chk_jabber_latch: assert property (
    PHY_EVT.jabber |=> st_r.jab_latch)
    else $error("Jabber did not latch");

  chk_read_release: assert property (
    rd_status && !PHY_EVT.remote_fault
      |=> !st_r.rf_latch)
    else $error("Remote fault not released by read");

  chk_pause_single: assert property (
    !(PAUSE_SYM_EN && PAUSE_ASYM_EN))
    else $error("Both pause settings active");

  chk_page_ack: assert property (
    PHY_EVT.page_rx |=> st_r.lp[14] && !st_r.lp[15]
      && st_r.lp[12] == 1'b0)
    else $error("Partner page not acknowledged");

  chk_adv_reserved: assert property (
    st_r.adv[15:14] == 2'b00 && !st_r.adv[12] && !st_r.adv[9])
    else $error("Reserved advertisement bit set");

  chk_unmapped_zero: assert property (
    MGMT_REQ.rd && (MGMT_REQ.index == 5'h00 || MGMT_REQ.index > 5'h05)
      |=> REG_RDATA == 16'h0000)
    else $error("Unmapped index read not zero");

  chk_ident_write: assert property (
    MGMT_REQ.wr && MGMT_REQ.index == IDX_IDENT_H
      |=> st_r.ident_high == $past(MGMT_REQ.wdata))
    else $error("Identifier write lost");

  cov_page_rx: cover property (
    PHY_EVT.page_rx ##1 rd_status);

  cov_pause_sym: cover property (
    $rose(PAUSE_SYM_EN));

  cov_fault_read: cover property (
    PHY_EVT.remote_fault ##[1:4] rd_status);

  cov_adv_write: cover property (
    MGMT_REQ.wr && MGMT_REQ.index == IDX_ADV);

endmodule : phy_status_autoneg_regs

/* tb/mac_mgmt_model.sv */
// MAC-side model that issues indexed PHY register accesses
`timescale 1ns/1ps

module mac_mgmt_model
(
  input  wire logic                       SYS_CLK,
  output phy_regs_pkg::mgmt_req_type       MGMT_REQ,
  input  wire logic [15:0]                REG_RDATA,
  input  wire logic                       REG_RVALID
);
  import phy_regs_pkg::*;

  initial MGMT_REQ = '0;

  // One access per call: held from just after an edge up to the taking edge
  task automatic access(input logic rd, input logic wr, input logic [4:0] idx,
                        input logic [15:0] wd, output logic [15:0] rdat, output logic ok);
    @(posedge SYS_CLK);
    #5;
    MGMT_REQ = '{rd: rd, wr: wr, index: idx, wdata: wd};
    @(posedge SYS_CLK);
    #5;
    ok   = (REG_RVALID === rd);
    rdat = REG_RDATA;
    // Released index and data lines show the inverse, so a stale value is never read by luck
    MGMT_REQ = '{rd: 1'b0, wr: 1'b0, index: ~idx, wdata: ~wd};
  endtask : access
endmodule : mac_mgmt_model

/* tb/tb_top.sv */
// Self-checking bench for the PHY status and auto-negotiation registers
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top;
  import phy_regs_pkg::*;

  logic          sys_clk;
  logic          sys_rst;
  mgmt_req_type  req;
  phy_event_type evt;
  logic [15:0]   rdata;
  logic          rvalid;
  logic [15:0]   adv_word;
  logic          p_sym;
  logic          p_asym;
  int            bad_count;
  int            checked;

  // Clock at 20 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  phy_status_autoneg_regs u_phy_status_autoneg_regs (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .MGMT_REQ(req), .PHY_EVT(evt),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .ADV_WORD(adv_word),
    .PAUSE_SYM_EN(p_sym), .PAUSE_ASYM_EN(p_asym));

  mac_mgmt_model u_mac_mgmt_model (
    .SYS_CLK(sys_clk), .MGMT_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_mac_mgmt_model.access(1'b1, 1'b0, idx, 16'h0000, d, ok);
    `CHK("read valid", 1'b1, ok)
    `CHK("read data", exp, d)
  endtask : rd

  task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
    logic [15:0] d;
    logic        ok;
    u_mac_mgmt_model.access(1'b0, 1'b1, idx, wd, d, ok);
    `CHK("no valid on write", 1'b1, ok)
  endtask : wr

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : cycles

  // Every register from reset, plus an unmapped index
  task automatic t_reset;
    rd(IDX_STATUS, 16'h7809);
    rd(IDX_IDENT_H, 16'h5a5a);
    rd(IDX_IDENT_L, 16'h54a1);
    rd(IDX_ADV, 16'h01e1);
    rd(IDX_PARTNER, 16'h0001);
    rd(5'h00, 16'h0000);
    `CHK("adv word", 16'h01e1, adv_word)
  endtask : t_reset

  // Writable, read-only and reserved bits
  task automatic t_writes;
    wr(IDX_ADV, 16'hffff);
    rd(IDX_ADV, 16'h2dff);
    `CHK("adv word", 16'h2dff, adv_word)
    wr(IDX_STATUS, 16'h0000);
    rd(IDX_STATUS, 16'h7809);
    wr(IDX_PARTNER, 16'hffff);
    rd(IDX_PARTNER, 16'h0001);
    wr(IDX_IDENT_H, 16'h1234);
    rd(IDX_IDENT_H, 16'h1234);
    wr(IDX_IDENT_L, 16'hc3a5);
    rd(IDX_IDENT_L, 16'hc3a5);
  endtask : t_writes

  // Latched fault, jabber and link flags across reads
  task automatic t_latch;
    evt.link_up      = 1'b1;
    evt.remote_fault = 1'b1;
    evt.jabber       = 1'b1;
    cycles(1);
    evt.remote_fault = 1'b0;
    evt.jabber       = 1'b0;
    cycles(2);
    rd(IDX_STATUS, 16'h781b);
    rd(IDX_STATUS, 16'h780d);
    evt.link_up = 1'b0;
    cycles(1);
    evt.link_up = 1'b1;
    cycles(2);
    rd(IDX_STATUS, 16'h7809);
    rd(IDX_STATUS, 16'h780d);
  endtask : t_latch

  // Base page capture, then pause resolution for every advertised code
  task automatic t_page;
    evt.page_word = 16'hffff;
    evt.page_rx   = 1'b1;
    cycles(1);
    evt.page_rx   = 1'b0;
    evt.page_word = 16'h0000;
    rd(IDX_PARTNER, 16'h6fff);
    evt.an_complete = 1'b1;
    rd(IDX_STATUS, 16'h782d);
    for (int p = 0; p < 4; p++)
    begin
      wr(IDX_ADV, 16'h01e1 | (16'(p) << 10));
      cycles(2);
      `CHK("pause sym", p[0], p_sym)
      `CHK("pause asym", ~p[0] & p[1], p_asym)
    end
    evt.an_complete = 1'b0;
    cycles(2);
    `CHK("pause off", 2'b00, {p_sym, p_asym})
  endtask : t_page

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  // Reset for 20 cycles, then the scenarios
  initial
  begin
    bad_count = 0;
    checked   = 0;
    sys_rst   = 1'b1;
    evt       = '0;
    repeat (20) @(posedge sys_clk);
    #5;
    sys_rst = 1'b0;
    t_reset();
    t_writes();
    t_latch();
    t_page();
    close_out();
  end
endmodule : tb_top
